// ==== pkg/mq_switch_pkg.sv ====
// constants and types shared by both ends of the multi-queue switch link
package mq_switch_pkg;
    localparam int QUEUE_COUNT = 128;
    localparam int QADDR_W = 8;
    localparam int QIDX_W = 7;
    localparam int DATA_W = 40;
    localparam int SLOT_W = 2;
    localparam int QUEUE_DEPTH = 4;
    localparam int PTR_W = 3;
    localparam int MEM_WORDS = QUEUE_COUNT * QUEUE_DEPTH;
    localparam int NUM_PORTS = 2;
    localparam int PORT_WR = 0;
    localparam int PORT_RD = 1;
    localparam int SWITCH_CYCLES = 4;
    localparam int BUF_DEPTH = 2;
    localparam logic [PTR_W-1:0] PTR_RESET = 3'h0;
    localparam logic [PTR_W-1:0] PTR_ONE = 3'h1;
    localparam logic [PTR_W-1:0] DEPTH_COUNT = 3'h4;
    localparam logic [PTR_W-1:0] ALMOST_FULL_LEVEL = 3'h3;
    localparam logic [PTR_W-1:0] ALMOST_EMPTY_LEVEL = 3'h1;
    localparam logic [QIDX_W-1:0] QUEUE_RESET = 7'h00;
    localparam logic [QADDR_W-1:0] QADDR_RESET = 8'h00;
    localparam logic [2:0] HOLD_COUNT = 3'h3;
    localparam logic [2:0] HOLD_ZERO = 3'h0;
    localparam logic [1:0] BUF_FULL = 2'h2;
    localparam logic [1:0] BUF_EMPTY = 2'h0;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_CYCLE_MARK = 4'h2,
        ST_CYCLE_GAP = 4'h4,
        ST_CYCLE_FLAG_UPDATE = 4'h8
    } switch_state_t;
endpackage

// ==== pkg/mq_link_if.sv ====
// link between the queue-managing controller and the multi-queue device
`timescale 1ns/1ps
interface mq_link_if (
    input wire logic clk,
    input wire logic rstn
);
    import mq_switch_pkg::*;
    logic wr_addr_enable;
    logic [QADDR_W-1:0] wr_queue_addr;
    logic wr_en;
    logic [DATA_W-1:0] wr_data;
    logic full_ind;
    logic almost_full_ind;
    logic rd_addr_enable;
    logic [QADDR_W-1:0] rd_queue_addr;
    logic rd_en;
    logic [DATA_W-1:0] rd_data;
    logic rd_valid;
    logic empty_ind;
    logic almost_empty_ind;

    modport device (
        input wr_addr_enable, wr_queue_addr, wr_en, wr_data,
        input rd_addr_enable, rd_queue_addr, rd_en,
        output full_ind, almost_full_ind, rd_data, rd_valid, empty_ind, almost_empty_ind
    );
    modport controller (
        output wr_addr_enable, wr_queue_addr, wr_en, wr_data,
        output rd_addr_enable, rd_queue_addr, rd_en,
        input full_ind, almost_full_ind, rd_data, rd_valid, empty_ind, almost_empty_ind
    );
endinterface

// ==== verilog/mq_device.sv ====
// multi-queue device end: queue storage, per-port switch sequencers, read buffer
//
// Behaviour
// - write address enable high selects new write queue
// - write enable never chooses the queue
// - write switch takes four write clocks
// - one switch per port every four clocks
// - queues may be selected in any order
// - writes continue into present queue during switch
// - write and read ports switch independently, simultaneously
// - first cycle takes request, second marks
// - full flags follow next queue in fourth cycle
// - writes enter next queue after fourth cycle
// - read address enable high selects new read queue
// - read enable never chooses the queue
// - read switch takes four read clocks
// - reads continue from present queue during switch
// - no back-off-one mode; a read rewind returns to the last committed read location
// - up to 128 queues behind shared ports
// - read queue address is eight bits
// - empty flags follow next queue, then data
// - active write enable commits, inactive rewinds for rewrite
// - address enable in mark cycle marks next queue
// - inactive read enable keeps old read location
`timescale 1ns/1ps
module mq_device (
    input wire logic clk,
    input wire logic rstn,
    mq_link_if.device link,
    output logic wr_mark_active,
    output logic [mq_switch_pkg::QIDX_W-1:0] wr_mark_queue,
    output logic rd_mark_active,
    output logic [mq_switch_pkg::QIDX_W-1:0] rd_mark_queue,
    output logic [mq_switch_pkg::QIDX_W-1:0] wr_present_queue,
    output logic [mq_switch_pkg::QIDX_W-1:0] rd_present_queue,
    output logic wr_switch_busy,
    output logic rd_switch_busy
);
    import mq_switch_pkg::*;

    logic [NUM_PORTS-1:0] addr_en;
    logic [NUM_PORTS-1:0] port_en;
    logic [NUM_PORTS-1:0] busy;
    logic [NUM_PORTS-1:0] closing;
    logic [NUM_PORTS-1:0] commit;
    logic [NUM_PORTS-1:0] mark_on;
    logic [QIDX_W-1:0] req_q [NUM_PORTS];
    logic [QIDX_W-1:0] pq [NUM_PORTS];
    logic [QIDX_W-1:0] fq [NUM_PORTS];
    logic [QIDX_W-1:0] mq [NUM_PORTS];

    assign addr_en = {link.rd_addr_enable, link.wr_addr_enable};
    assign port_en = {link.rd_en, link.wr_en};
    // bit 7 is the expansion select; one device decodes the low seven bits
    assign req_q[PORT_WR] = link.wr_queue_addr[QIDX_W-1:0];
    assign req_q[PORT_RD] = link.rd_queue_addr[QIDX_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // switch sequencers, one per port, each on its own state
    generate
        for (genvar p = 0; p < NUM_PORTS; p++) begin : sw
            switch_state_t state_reg;
            switch_state_t state_next;
            logic [QIDX_W-1:0] pq_reg;
            logic [QIDX_W-1:0] pq_next;
            logic [QIDX_W-1:0] nq_reg;
            logic [QIDX_W-1:0] nq_next;
            logic [QIDX_W-1:0] fq_reg;
            logic [QIDX_W-1:0] fq_next;
            logic [QIDX_W-1:0] mq_reg;
            logic [QIDX_W-1:0] mq_next;
            logic upd_reg;
            logic upd_next;
            logic mark_reg;
            logic mark_next;

            always_comb begin
                state_next = state_reg;
                pq_next = pq_reg;
                nq_next = nq_reg;
                fq_next = fq_reg;
                mq_next = mq_reg;
                upd_next = upd_reg;
                mark_next = mark_reg;
                case (state_reg)
                    ST_IDLE: begin
                        // any queue may follow any other, including itself
                        if (addr_en[p]) begin
                            state_next = ST_CYCLE_MARK;
                            nq_next = req_q[p];
                            upd_next = port_en[p];
                        end
                    end
                    ST_CYCLE_MARK: begin
                        // only one queue marked per port; a switch without it unmarks
                        mark_next = addr_en[p];
                        if (addr_en[p]) begin
                            mq_next = nq_reg;
                        end
                        state_next = ST_CYCLE_GAP;
                    end
                    ST_CYCLE_GAP: begin
                        fq_next = nq_reg;
                        state_next = ST_CYCLE_FLAG_UPDATE;
                    end
                    ST_CYCLE_FLAG_UPDATE: begin
                        pq_next = nq_reg;
                        state_next = ST_IDLE;
                    end
                    default: begin
                        state_next = ST_IDLE;
                    end
                endcase
            end

            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    state_reg <= ST_IDLE;
                    pq_reg <= QUEUE_RESET;
                    nq_reg <= QUEUE_RESET;
                    fq_reg <= QUEUE_RESET;
                    mq_reg <= QUEUE_RESET;
                    upd_reg <= 1'b0;
                    mark_reg <= 1'b0;
                end else begin
                    state_reg <= state_next;
                    pq_reg <= pq_next;
                    nq_reg <= nq_next;
                    fq_reg <= fq_next;
                    mq_reg <= mq_next;
                    upd_reg <= upd_next;
                    mark_reg <= mark_next;
                end
            end

            assign pq[p] = pq_reg;
            assign fq[p] = fq_reg;
            assign mq[p] = mq_reg;
            assign mark_on[p] = mark_reg;
            assign commit[p] = upd_reg;
            assign busy[p] = (state_reg != ST_IDLE);
            assign closing[p] = (state_reg == ST_CYCLE_FLAG_UPDATE);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // queue storage: live and committed pointers per queue
    logic [DATA_W-1:0] mem_reg [MEM_WORDS];
    logic [DATA_W-1:0] mem_next [MEM_WORDS];
    logic [PTR_W-1:0] wp_reg [QUEUE_COUNT];
    logic [PTR_W-1:0] wp_next [QUEUE_COUNT];
    logic [PTR_W-1:0] wc_reg [QUEUE_COUNT];
    logic [PTR_W-1:0] wc_next [QUEUE_COUNT];
    logic [PTR_W-1:0] rp_reg [QUEUE_COUNT];
    logic [PTR_W-1:0] rp_next [QUEUE_COUNT];
    logic [PTR_W-1:0] rc_reg [QUEUE_COUNT];
    logic [PTR_W-1:0] rc_next [QUEUE_COUNT];
    logic [PTR_W-1:0] pq_wocc;
    logic [PTR_W-1:0] pq_ravail;
    logic [PTR_W-1:0] fq_wocc;
    logic [PTR_W-1:0] fq_ravail;
    logic wr_go;
    logic rd_go;
    logic buf_room;
    logic [DATA_W-1:0] rd_word;

    // writer is bounded by committed reads, reader sees only committed writes,
    // so a rewind on either side never exposes or overwrites live data
    assign pq_wocc = wp_reg[pq[PORT_WR]] - rc_reg[pq[PORT_WR]];
    assign pq_ravail = wc_reg[pq[PORT_RD]] - rp_reg[pq[PORT_RD]];
    assign fq_wocc = wp_reg[fq[PORT_WR]] - rc_reg[fq[PORT_WR]];
    assign fq_ravail = wc_reg[fq[PORT_RD]] - rp_reg[fq[PORT_RD]];
    // guard on the present queue, not the flag queue, since flags lead by a cycle
    assign wr_go = link.wr_en && (pq_wocc != DEPTH_COUNT);
    assign rd_go = link.rd_en && buf_room && (pq_ravail != PTR_RESET);
    assign rd_word = mem_reg[{pq[PORT_RD], rp_reg[pq[PORT_RD]][SLOT_W-1:0]}];

    assign link.full_ind = (fq_wocc == DEPTH_COUNT);
    assign link.almost_full_ind = (fq_wocc >= ALMOST_FULL_LEVEL);
    assign link.empty_ind = (fq_ravail == PTR_RESET);
    assign link.almost_empty_ind = (fq_ravail <= ALMOST_EMPTY_LEVEL);

    always_comb begin
        mem_next = mem_reg;
        wp_next = wp_reg;
        wc_next = wc_reg;
        rp_next = rp_reg;
        rc_next = rc_reg;
        if (wr_go) begin
            mem_next[{pq[PORT_WR], wp_reg[pq[PORT_WR]][SLOT_W-1:0]}] = link.wr_data;
            wp_next[pq[PORT_WR]] = wp_reg[pq[PORT_WR]] + PTR_ONE;
        end
        if (rd_go) begin
            rp_next[pq[PORT_RD]] = rp_reg[pq[PORT_RD]] + PTR_ONE;
        end
        // ports close their switches independently, even in the same cycle
        if (closing[PORT_WR]) begin
            if (commit[PORT_WR]) begin
                wc_next[pq[PORT_WR]] = wp_next[pq[PORT_WR]];
            end else begin
                wp_next[pq[PORT_WR]] = wc_reg[pq[PORT_WR]];
            end
        end
        if (closing[PORT_RD]) begin
            if (commit[PORT_RD]) begin
                rc_next[pq[PORT_RD]] = rp_next[pq[PORT_RD]];
            end else begin
                rp_next[pq[PORT_RD]] = rc_reg[pq[PORT_RD]];
            end
        end
    end

    // storage words carry no reset; only pointers define contents
    always_ff @(posedge clk) begin
        mem_reg <= mem_next;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < QUEUE_COUNT; i++) begin
                wp_reg[i] <= PTR_RESET;
                wc_reg[i] <= PTR_RESET;
                rp_reg[i] <= PTR_RESET;
                rc_reg[i] <= PTR_RESET;
            end
        end else begin
            wp_reg <= wp_next;
            wc_reg <= wc_next;
            rp_reg <= rp_next;
            rc_reg <= rc_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // two-entry read buffer; read enable doubles as the receiver's ready
    logic [DATA_W-1:0] buf_reg [BUF_DEPTH];
    logic [DATA_W-1:0] buf_next [BUF_DEPTH];
    logic head_reg;
    logic head_next;
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;
    logic pop;

    assign pop = (cnt_reg != BUF_EMPTY) && link.rd_en;
    // room ignores a same-cycle pop: one bubble traded for a short path
    assign buf_room = (cnt_reg != BUF_FULL);

    always_comb begin
        buf_next = buf_reg;
        head_next = head_reg;
        cnt_next = cnt_reg;
        if (rd_go) begin
            buf_next[head_reg ^ cnt_reg[0]] = rd_word;
        end
        if (pop) begin
            head_next = ~head_reg;
        end
        case ({rd_go, pop})
            2'b10: cnt_next = cnt_reg + 2'h1;
            2'b01: cnt_next = cnt_reg - 2'h1;
            default: cnt_next = cnt_reg;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            buf_reg[0] <= '0;
            buf_reg[1] <= '0;
            head_reg <= 1'b0;
            cnt_reg <= BUF_EMPTY;
        end else begin
            buf_reg <= buf_next;
            head_reg <= head_next;
            cnt_reg <= cnt_next;
        end
    end

    assign link.rd_valid = (cnt_reg != BUF_EMPTY);
    assign link.rd_data = buf_reg[head_reg];

    assign wr_mark_active = mark_on[PORT_WR];
    assign wr_mark_queue = mq[PORT_WR];
    assign rd_mark_active = mark_on[PORT_RD];
    assign rd_mark_queue = mq[PORT_RD];
    assign wr_present_queue = pq[PORT_WR];
    assign rd_present_queue = pq[PORT_RD];
    assign wr_switch_busy = busy[PORT_WR];
    assign rd_switch_busy = busy[PORT_RD];
endmodule

// ==== verilog/mq_controller.sv ====
// controller end: paces queue switches, drives address enables and data enables
`timescale 1ns/1ps
module mq_controller (
    input wire logic clk,
    input wire logic rstn,
    mq_link_if.controller link,
    input wire logic [mq_switch_pkg::NUM_PORTS-1:0] switch_req,
    input wire logic [mq_switch_pkg::NUM_PORTS-1:0][mq_switch_pkg::QADDR_W-1:0] switch_queue,
    input wire logic [mq_switch_pkg::NUM_PORTS-1:0] switch_mark,
    input wire logic [mq_switch_pkg::NUM_PORTS-1:0] switch_retain,
    output logic [mq_switch_pkg::NUM_PORTS-1:0] switch_ready,
    input wire logic wr_valid,
    input wire logic [mq_switch_pkg::DATA_W-1:0] wr_data,
    output logic wr_ready,
    input wire logic rd_ready,
    output logic rd_valid,
    output logic [mq_switch_pkg::DATA_W-1:0] rd_data,
    output logic wr_full,
    output logic wr_almost_full,
    output logic rd_empty,
    output logic rd_almost_empty
);
    import mq_switch_pkg::*;

    logic [NUM_PORTS-1:0] addr_en;
    logic [NUM_PORTS-1:0] hold;
    logic [QADDR_W-1:0] addr [NUM_PORTS];

    generate
        for (genvar p = 0; p < NUM_PORTS; p++) begin : pace
            logic [2:0] cnt_reg;
            logic [2:0] cnt_next;
            logic sel_reg;
            logic sel_next;
            logic markc_reg;
            logic markc_next;
            logic mark_reg;
            logic mark_next;
            logic retain_reg;
            logic retain_next;
            logic [QADDR_W-1:0] q_reg;
            logic [QADDR_W-1:0] q_next;
            logic accept;

            assign accept = switch_req[p] && (cnt_reg == HOLD_ZERO);

            always_comb begin
                cnt_next = (cnt_reg != HOLD_ZERO) ? cnt_reg - 3'h1 : HOLD_ZERO;
                sel_next = accept;
                markc_next = sel_reg && mark_reg;
                mark_next = mark_reg;
                retain_next = retain_reg;
                q_next = q_reg;
                if (accept) begin
                    cnt_next = HOLD_COUNT;
                    mark_next = switch_mark[p];
                    retain_next = switch_retain[p];
                    q_next = switch_queue[p];
                end
            end

            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    cnt_reg <= HOLD_ZERO;
                    sel_reg <= 1'b0;
                    markc_reg <= 1'b0;
                    mark_reg <= 1'b0;
                    retain_reg <= 1'b0;
                    q_reg <= QADDR_RESET;
                end else begin
                    cnt_reg <= cnt_next;
                    sel_reg <= sel_next;
                    markc_reg <= markc_next;
                    mark_reg <= mark_next;
                    retain_reg <= retain_next;
                    q_reg <= q_next;
                end
            end

            assign switch_ready[p] = (cnt_reg == HOLD_ZERO);
            assign addr_en[p] = sel_reg || markc_reg;
            assign addr[p] = q_reg;
            // enable held inactive in the select cycle asks to keep the old location
            assign hold[p] = sel_reg && retain_reg;
        end
    endgenerate

    logic wr_flag_cycle_reg;
    logic wr_flag_cycle_next;

    // marks the write switch's flag-update cycle, one cycle after its gap cycle
    always_comb begin
        wr_flag_cycle_next = (pace[PORT_WR].cnt_reg == 3'h1);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_flag_cycle_reg <= 1'b0;
        end else begin
            wr_flag_cycle_reg <= wr_flag_cycle_next;
        end
    end

    assign link.wr_addr_enable = addr_en[PORT_WR];
    assign link.wr_queue_addr = addr[PORT_WR];
    assign link.rd_addr_enable = addr_en[PORT_RD];
    assign link.rd_queue_addr = addr[PORT_RD];

    // in the flag-update cycle full already shows the next queue while writes
    // still land in the old one; that slot is given up so no word is dropped
    assign wr_ready = !link.full_ind && !hold[PORT_WR] && !wr_flag_cycle_reg;
    assign link.wr_en = wr_valid && wr_ready;
    assign link.wr_data = wr_data;
    assign link.rd_en = rd_ready && !hold[PORT_RD];
    assign rd_valid = link.rd_valid && !hold[PORT_RD];
    assign rd_data = link.rd_data;

    assign wr_full = link.full_ind;
    assign wr_almost_full = link.almost_full_ind;
    assign rd_empty = link.empty_ind;
    assign rd_almost_empty = link.almost_empty_ind;
endmodule

// ==== tb/mq_switch_sva.sv ====
// concurrent checks on the link between controller and device
`timescale 1ns/1ps
module mq_switch_sva (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wr_addr_enable,
    input wire logic [mq_switch_pkg::QADDR_W-1:0] wr_queue_addr,
    input wire logic rd_addr_enable,
    input wire logic [mq_switch_pkg::QADDR_W-1:0] rd_queue_addr,
    input wire logic rd_en,
    input wire logic [mq_switch_pkg::DATA_W-1:0] rd_data,
    input wire logic rd_valid,
    input wire logic full_ind,
    input wire logic almost_full_ind,
    input wire logic empty_ind,
    input wire logic almost_empty_ind
);
    import mq_switch_pkg::*;
    logic [2:0] rd_gap_reg;
    logic [2:0] rd_gap_next;
    logic rd_prev_reg;
    logic rd_prev_next;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////
    // cycles since the last read select, saturating
    always_comb begin
        rd_prev_next = rd_addr_enable;
        rd_gap_next = (rd_gap_reg == 3'h7) ? rd_gap_reg : rd_gap_reg + 3'h1;
        if (rd_addr_enable && !rd_prev_reg) begin
            rd_gap_next = 3'h1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_gap_reg <= 3'h4;
            rd_prev_reg <= 1'b0;
        end else begin
            rd_gap_reg <= rd_gap_next;
            rd_prev_reg <= rd_prev_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    sequence wr_select;
        !wr_addr_enable ##1 wr_addr_enable;
    endsequence

    a_wr_switch_spacing: assert property (wr_select |-> ##2 !wr_addr_enable [*2])
        else $error("write select closer than four cycles");
    a_rd_switch_spacing: assert property (rd_addr_enable && !rd_prev_reg |-> rd_gap_reg >= 3'h4)
        else $error("read select closer than four cycles");
    a_wr_mark_len: assert property (wr_addr_enable [*2] |=> !wr_addr_enable)
        else $error("write address enable high beyond mark cycle");
    a_wr_addr_hold: assert property (wr_addr_enable && $past(wr_addr_enable) |-> $stable(wr_queue_addr))
        else $error("write queue address moved in mark cycle");
    a_rd_addr_hold: assert property (rd_addr_enable && $past(rd_addr_enable) |-> $stable(rd_queue_addr))
        else $error("read queue address moved in mark cycle");
    a_rd_word_hold: assert property (rd_valid && !rd_en |=> rd_valid && $stable(rd_data))
        else $error("read word lost while stalled");
    a_full_level: assert property (full_ind |-> almost_full_ind)
        else $error("full without almost full");
    a_empty_level: assert property (empty_ind |-> almost_empty_ind)
        else $error("empty without almost empty");
endmodule

// ==== tb/tb.sv ====
// self-checking bench for controller and device joined over the link
`timescale 1ns/1ps
module tb;
    import mq_switch_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [NUM_PORTS-1:0] switch_req = '0;
    logic [NUM_PORTS-1:0][QADDR_W-1:0] switch_queue = '0;
    logic [NUM_PORTS-1:0] switch_mark = '0;
    logic [NUM_PORTS-1:0] switch_retain = '0;
    logic [NUM_PORTS-1:0] switch_ready;
    logic wr_valid = 1'b0;
    logic [DATA_W-1:0] wr_data = '0;
    logic rd_ready = 1'b0;
    logic wr_ready, rd_valid, wr_full, wr_almost_full, rd_empty, rd_almost_empty;
    logic [DATA_W-1:0] rd_data;
    logic [NUM_PORTS-1:0] mark_act, busy;
    logic [NUM_PORTS-1:0][QIDX_W-1:0] mark_q, pres;
    logic [31:0] seed = 32'h5711C093;
    logic [DATA_W-1:0] expq[$];
    int n_errors = 0;
    int tests_run = 0;

    always #5 clk = ~clk;

    mq_link_if link_bus (.clk(clk), .rstn(rstn));

    mq_device i_mq_device (.clk(clk), .rstn(rstn), .link(link_bus),
        .wr_mark_active(mark_act[PORT_WR]), .wr_mark_queue(mark_q[PORT_WR]),
        .rd_mark_active(mark_act[PORT_RD]), .rd_mark_queue(mark_q[PORT_RD]),
        .wr_present_queue(pres[PORT_WR]), .rd_present_queue(pres[PORT_RD]),
        .wr_switch_busy(busy[PORT_WR]), .rd_switch_busy(busy[PORT_RD]));

    mq_controller i_mq_controller (.clk(clk), .rstn(rstn), .link(link_bus),
        .switch_req(switch_req), .switch_queue(switch_queue), .switch_mark(switch_mark),
        .switch_retain(switch_retain), .switch_ready(switch_ready), .wr_valid(wr_valid),
        .wr_data(wr_data), .wr_ready(wr_ready), .rd_ready(rd_ready), .rd_valid(rd_valid),
        .rd_data(rd_data), .wr_full(wr_full), .wr_almost_full(wr_almost_full),
        .rd_empty(rd_empty), .rd_almost_empty(rd_almost_empty));

    mq_switch_sva i_mq_switch_sva (.clk(clk), .rstn(rstn),
        .wr_addr_enable(link_bus.wr_addr_enable), .wr_queue_addr(link_bus.wr_queue_addr),
        .rd_addr_enable(link_bus.rd_addr_enable), .rd_queue_addr(link_bus.rd_queue_addr),
        .rd_en(link_bus.rd_en), .rd_data(link_bus.rd_data), .rd_valid(link_bus.rd_valid),
        .full_ind(link_bus.full_ind), .almost_full_ind(link_bus.almost_full_ind),
        .empty_ind(link_bus.empty_ind), .almost_empty_ind(link_bus.almost_empty_ind));

    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // only the low seven address bits pick a queue
    function automatic logic [QIDX_W-1:0] exp_queue(input logic [QADDR_W-1:0] a);
        return a[QIDX_W-1:0];
    endfunction

    task automatic chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // one switch on port p; ef is the flag expected in the flag-update cycle, -1 skips
    task automatic sw(input int p, input logic [QADDR_W-1:0] q, input logic mk,
        input logic rt, input int ef);
        logic [QIDX_W-1:0] old;
        int k;
        k = 0;
        @(posedge clk);
        while (switch_ready[p] !== 1'b1 && k < 20) begin
            @(posedge clk);
            k++;
        end
        if (k == 20) begin
            chk(1'b0, "switch ready timeout");
            close_out();
        end
        old = pres[p];
        switch_req[p] <= 1'b1;
        switch_queue[p] <= q;
        switch_mark[p] <= mk;
        switch_retain[p] <= rt;
        @(posedge clk);
        switch_req[p] <= 1'b0;
        for (int c = 1; c <= 4; c++) begin
            @(posedge clk);
            #1;
            if (c == 1) chk(busy[p] === 1'b1, "busy missing");
            if (c == 2) chk(mark_act[p] === mk, "mark state wrong");
            if (c == 2 && mk) chk(mark_q[p] === exp_queue(q), "mark queue wrong");
            if (c == 3 && ef >= 0 && p == PORT_WR) chk(full_ind_w() === ef[0], "full flag");
            if (c == 3 && ef >= 0 && p == PORT_RD) chk(rd_empty === ef[0], "empty flag");
            if (c < 4) chk(pres[p] === old, "queue changed early");
            if (c == 4) chk(pres[p] === exp_queue(q), "queue not switched");
        end
    endtask

    function automatic logic full_ind_w();
        return wr_full;
    endfunction

    ////////////////////////////////////////////////////////////////
    initial begin
        int got;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        chk(rd_empty === 1'b1 && rd_almost_empty === 1'b1 && wr_full === 1'b0, "reset flags");
        chk(switch_ready === 2'h3 && pres === '0 && busy === 2'h0, "reset state");
        // four beats overlap a committing switch; the third leaves the old queue almost full
        fork
            for (int i = 0; i < 5; i++) begin
                @(negedge clk);
                if (wr_valid && wr_ready && expq.size() < 4) expq.push_back(wr_data);
                if (i == 4) chk(wr_full === 1'b0 && wr_almost_full === 1'b1, "almost full");
                @(posedge clk);
                seed = xs(seed);
                wr_valid <= (i < 4) ? 1'b1 : 1'b0;
                wr_data <= {seed[7:0], seed};
            end
            sw(PORT_WR, 8'h05, 1'b0, 1'b0, 0);
        join
        // drain the old queue with a stalling receiver
        got = 0;
        for (int i = 0; i < 80; i++) begin
            @(posedge clk);
            if (rd_valid && rd_ready) begin
                chk(expq.size() > 0 && rd_data === expq[0], "read word wrong");
                if (expq.size() > 0) expq.pop_front();
                got++;
            end
            seed = xs(seed);
            rd_ready <= seed[0];
        end
        chk(got == 4 && rd_valid === 1'b0, "read count");
        // writes left uncommitted by a rewrite switch stay invisible
        wr_valid <= 1'b1;
        repeat (2) @(posedge clk);
        wr_valid <= 1'b0;
        sw(PORT_WR, 8'h09, 1'b1, 1'b1, -1);
        sw(PORT_RD, 8'h05, 1'b0, 1'b0, 1);
        // both ports at once, random queues, address bit 7 set first (write 8'hFF, read 8'h80)
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            seed = xs(seed);
            wr_valid <= seed[8];
            rd_ready <= seed[9];
            fork
                sw(PORT_WR, (i == 0) ? 8'hFF : seed[7:0], seed[10], 1'b0, -1);
                sw(PORT_RD, (i == 0) ? 8'h80 : seed[23:16], seed[11], 1'b0, -1);
            join
        end
        close_out();
    end
endmodule
